//--- ctd_params.svh
// register indices, field positions, reset values and filter counts for the timer block
`ifndef CTD_PARAMS_SVH
`define CTD_PARAMS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CTD_IDX_NARROW_CTRL   4'h0
`define CTD_IDX_COMMON        4'h1
`define CTD_IDX_WIDE_CTRL     4'h2
`define CTD_IDX_SHARED_THREE  4'h3
`define CTD_IDX_WRELOAD_LOW   4'h4
`define CTD_IDX_WRELOAD_HIGH  4'h5
`define CTD_IDX_WCAP_LOW      4'h6
`define CTD_IDX_WCAP_HIGH     4'h7
`define CTD_IDX_NCAP_LOW      4'h8
`define CTD_IDX_NCAP_HIGH     4'h9
`define CTD_IDX_NRELOAD       4'hA

// ---------------------------------------------------------------
// common control fields
// ---------------------------------------------------------------
`define CTD_CC_MODE           7
`define CTD_CC_PINSEL         6
`define CTD_CC_EDGE_HI        5
`define CTD_CC_EDGE_LO        4
`define CTD_CC_GLITCH_HI      3
`define CTD_CC_GLITCH_LO      2
`define CTD_CC_STAT_RISE      1
`define CTD_CC_STAT_FALL      0

// ---------------------------------------------------------------
// narrow and wide control fields
// ---------------------------------------------------------------
`define CTD_NC_ENABLE         0
`define CTD_NC_CAP_MASK       1
`define CTD_NC_CNT_MASK       2
`define CTD_NC_ROUTE          3
`define CTD_NC_PORT_A         4
`define CTD_NC_PORT_B         5
`define CTD_WC_ENABLE         7
`define CTD_WC_CAPMODE        6
`define CTD_WC_CAP_IE         2

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define CTD_RST_BYTE          8'h00
`define CTD_RST_WORD          16'h0000
`define CTD_WIDE_FULL         16'hFFFF
`define CTD_RESERVED_ONES     5'h1F
`define CTD_EDGE_FALL         2'h0
`define CTD_EDGE_RISE         2'h1
`define CTD_EDGE_BOTH         2'h2

// ---------------------------------------------------------------
// glitch filter widths in clock cycles
// ---------------------------------------------------------------
`define CTD_GLITCH_W0         4'h1
`define CTD_GLITCH_W1         4'h2
`define CTD_GLITCH_W2         4'h4
`define CTD_GLITCH_W3         4'h8

`endif

//--- ctd_pkg.sv
// types shared by the timer block
package ctd_pkg;

    // ---------------------------------------------------------------
    // wide timer demodulation sequence
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CTD_W_IDLE,
        CTD_W_ARMED,
        CTD_W_COUNT
    } ctd_wstate_type;

endpackage : ctd_pkg

//--- ctd_edge_filter.sv
// synchroniser, glitch filter and edge pulse generator for the demodulator input
`timescale 1ns/1ps
`include "ctd_params.svh"

module ctd_edge_filter
    import ctd_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // raw pin and filter width
    input  wire logic       pin_raw,
    input  wire logic [1:0] width_sel,
    // filtered edge pulses
    output logic            rise_q,
    output logic            fall_q
);

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic       sync1_q;   // first sync stage, read only by sync2_q
    logic       sync2_q;   // second sync stage
    logic       level_q;   // accepted filtered level
    logic [3:0] run_q;     // cycles the new level has been stable
    logic [3:0] limit;     // required stable width

    // width select to cycle count
    always_comb begin
        case (width_sel)
            2'h0:    limit = `CTD_GLITCH_W0;
            2'h1:    limit = `CTD_GLITCH_W1;
            2'h2:    limit = `CTD_GLITCH_W2;
            default: limit = `CTD_GLITCH_W3;
        endcase
    end

    // two-stage synchroniser for the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (ce) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // accept a new level only after it is stable for limit cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b1;
            run_q   <= 4'h0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end else if (ce) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            if (sync2_q == level_q) begin
                run_q <= 4'h0;                       // short pulse dropped
            end else if (run_q + 4'h1 >= limit) begin
                level_q <= sync2_q;
                run_q   <= 4'h0;
                rise_q  <= sync2_q;
                fall_q  <= ~sync2_q;
            end else begin
                run_q <= run_q + 4'h1;
            end
        end
    end

endmodule : ctd_edge_filter

//--- ctd_top.sv
// carrier timer and demodulator: two counters, shared control and APB registers
// Function
// - demod input from selected pin, edge detected
// - edge select field bits five, four
// - 00 falling, 01 rising, 10 both
// - glitch filter width from bits three, two
// - idle narrow output is inverse bit one
// - zero count wraps, wrap not timeout
// - first edge captures, reloads, starts counting
// - later edges capture complemented count
// - later wide capture sets matching edge status bit
// - capture interrupt only when enabled
// - reload all ones after each later capture
// - capture mask permits narrow capture interrupt
// - counter mask permits narrow timeout interrupt
// - route select picks port or timer output
// - mode bit seven, change only when disabled
`timescale 1ns/1ps
`include "ctd_params.svh"

module ctd_top
    import ctd_pkg::*;
(
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    // pins
    input  wire logic        demod_input_pin_a,
    input  wire logic        demod_input_pin_b,
    output logic             timer_out_pin_q,
    output logic             output_or_input_pin_q,
    // interrupt requests
    output logic             capture_irq_q,
    output logic             counter_irq_q
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0]     narrow_ctrl_q;   // narrow timer control
    logic [7:0]     common_q;        // common control
    logic [7:0]     wide_ctrl_q;     // wide timer control
    logic [2:0]     shared_hi_q;     // writable top of shared register three
    logic [7:0]     wreload_lo_q;    // wide reload low
    logic [7:0]     wreload_hi_q;    // wide reload high
    logic [15:0]    wcap_q;          // wide capture high and low
    logic [7:0]     ncap_lo_q;       // narrow capture low
    logic [7:0]     ncap_hi_q;       // narrow capture high
    logic [7:0]     nreload_q;       // narrow reload
    logic [15:0]    wcnt_q;          // wide counter
    logic [7:0]     ncnt_q;          // narrow counter
    logic           nen_dly_q;       // narrow enable, one cycle late
    logic           narrow_out_q;    // narrow timer output level
    logic           wide_out_q;      // wide timer output level
    ctd_wstate_type wstate_q;        // wide demod sequence

    // ---------------------------------------------------------------
    // decode and shared terms
    // ---------------------------------------------------------------
    logic        wr_go;       // write takes effect this edge
    logic [3:0]  idx;         // register index
    logic        mapped;      // index hits a register
    logic        demod;       // demodulation mode
    logic        nen;         // narrow enabled
    logic        wen;         // wide enabled
    logic        rise_p;      // filtered rising edge
    logic        fall_p;      // filtered falling edge
    logic        edge_hit;    // qualifying edge
    logic        wcap_ev;     // wide capture this cycle
    logic        ncap_ev;     // narrow capture this cycle
    logic        ntimeout;    // narrow timeout this cycle
    logic        wtimeout;    // wide timeout this cycle
    logic [7:0]  rd_byte;     // read mux
    logic [15:0] wreload;     // wide reload word

    assign idx      = paddr[5:2];
    assign wr_go    = psel & penable & pready_q & pwrite;
    assign mapped   = (idx <= `CTD_IDX_NRELOAD);
    assign demod    = common_q[`CTD_CC_MODE];
    assign nen      = narrow_ctrl_q[`CTD_NC_ENABLE];
    assign wen      = wide_ctrl_q[`CTD_WC_ENABLE];
    assign wreload  = {wreload_hi_q, wreload_lo_q};
    assign ntimeout = nen & nen_dly_q & (ncnt_q == 8'h01);
    assign wtimeout = wen & ~demod & (wcnt_q == 16'h0001);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0]  pin_s1_q;    // first stage, read only by pin_s2_q
    logic [1:0]  pin_s2_q;    // second stage, safe for the select mux

    // both pins settle here before the select mux reads them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
        end else if (ce) begin
            pin_s1_q <= {demod_input_pin_b, demod_input_pin_a};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // input circuit
    // ---------------------------------------------------------------
    ctd_edge_filter u_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_raw   (common_q[`CTD_CC_PINSEL] ? pin_s2_q[1] : pin_s2_q[0]),
        .width_sel (common_q[`CTD_CC_GLITCH_HI:`CTD_CC_GLITCH_LO]),
        .rise_q    (rise_p),
        .fall_q    (fall_p)
    );

    // edge qualification from the edge select field
    always_comb begin
        case (common_q[`CTD_CC_EDGE_HI:`CTD_CC_EDGE_LO])
            `CTD_EDGE_FALL: edge_hit = fall_p;
            `CTD_EDGE_RISE: edge_hit = rise_p;
            `CTD_EDGE_BOTH: edge_hit = rise_p | fall_p;
            default:        edge_hit = 1'b0;
        endcase
    end

    assign wcap_ev = demod & wen & edge_hit & (wstate_q == CTD_W_COUNT)
                     & ~wide_ctrl_q[`CTD_WC_CAPMODE];
    assign ncap_ev = demod & nen & edge_hit;

    // ---------------------------------------------------------------
    // apb handshake and read data
    // ---------------------------------------------------------------
    always_comb begin
        case (idx)
            `CTD_IDX_NARROW_CTRL:  rd_byte = narrow_ctrl_q;
            `CTD_IDX_COMMON:       rd_byte = common_q;
            `CTD_IDX_WIDE_CTRL:    rd_byte = wide_ctrl_q;
            `CTD_IDX_SHARED_THREE: rd_byte = {shared_hi_q, `CTD_RESERVED_ONES};
            `CTD_IDX_WRELOAD_LOW:  rd_byte = wreload_lo_q;
            `CTD_IDX_WRELOAD_HIGH: rd_byte = wreload_hi_q;
            `CTD_IDX_WCAP_LOW:     rd_byte = wcap_q[7:0];
            `CTD_IDX_WCAP_HIGH:    rd_byte = wcap_q[15:8];
            `CTD_IDX_NCAP_LOW:     rd_byte = ncap_lo_q;
            `CTD_IDX_NCAP_HIGH:    rd_byte = ncap_hi_q;
            `CTD_IDX_NRELOAD:      rd_byte = nreload_q;
            default:               rd_byte = 8'h00;
        endcase
    end

    // ready rises one cycle after setup, read data sampled at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            if (psel & ~penable & ~pready_q) begin
                pready_q  <= 1'b1;
                pslverr_q <= ~mapped;
                prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end else begin
                pready_q  <= 1'b0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // software control registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            narrow_ctrl_q <= `CTD_RST_BYTE;
            wide_ctrl_q   <= `CTD_RST_BYTE;
            shared_hi_q   <= 3'h0;
            wreload_lo_q  <= `CTD_RST_BYTE;
            wreload_hi_q  <= `CTD_RST_BYTE;
            nreload_q     <= `CTD_RST_BYTE;
        end else if (ce && wr_go && mapped) begin
            case (idx)
                `CTD_IDX_NARROW_CTRL:  narrow_ctrl_q <= pwdata[7:0];
                `CTD_IDX_WIDE_CTRL:    wide_ctrl_q   <= pwdata[7:0];
                `CTD_IDX_SHARED_THREE: shared_hi_q   <= pwdata[7:5];
                `CTD_IDX_WRELOAD_LOW:  wreload_lo_q  <= pwdata[7:0];
                `CTD_IDX_WRELOAD_HIGH: wreload_hi_q  <= pwdata[7:0];
                `CTD_IDX_NRELOAD:      nreload_q     <= pwdata[7:0];
                default:               nreload_q     <= nreload_q;
            endcase
        end
    end

    // common control: mode locked while a timer runs, status sticky
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            common_q <= `CTD_RST_BYTE;
        end else if (ce) begin
            if (wr_go && idx == `CTD_IDX_COMMON) begin
                if (!(nen | wen)) begin
                    common_q[`CTD_CC_MODE] <= pwdata[`CTD_CC_MODE];
                end
                common_q[6:2] <= pwdata[6:2];
                if (!demod) begin
                    common_q[1:0] <= pwdata[1:0];
                end else begin
                    common_q[1:0] <= common_q[1:0] & ~pwdata[1:0];
                end
            end
            if (wcap_ev && rise_p) begin
                common_q[`CTD_CC_STAT_RISE] <= 1'b1;
            end
            if (wcap_ev && fall_p) begin
                common_q[`CTD_CC_STAT_FALL] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // wide timer
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wstate_q   <= CTD_W_IDLE;
            wcnt_q     <= `CTD_RST_WORD;
            wcap_q     <= `CTD_RST_WORD;
            wide_out_q <= 1'b0;
        end else if (ce) begin
            case (wstate_q)
                CTD_W_IDLE: begin
                    if (wen) begin
                        wcnt_q   <= wreload;
                        wstate_q <= demod ? CTD_W_ARMED : CTD_W_COUNT;
                    end
                end
                CTD_W_ARMED: begin
                    if (!wen) begin
                        wstate_q <= CTD_W_IDLE;
                    end else if (edge_hit) begin
                        wcap_q   <= ~wcnt_q;
                        wcnt_q   <= wreload;
                        wstate_q <= CTD_W_COUNT;
                    end
                end
                CTD_W_COUNT: begin
                    if (!wen) begin
                        wstate_q <= CTD_W_IDLE;
                    end else if (wcap_ev) begin
                        wcap_q <= ~wcnt_q;
                        wcnt_q <= `CTD_WIDE_FULL;
                    end else if (wtimeout) begin
                        wcnt_q     <= wreload;
                        wide_out_q <= ~wide_out_q;
                    end else begin
                        wcnt_q <= wcnt_q - 16'h0001;
                    end
                end
                default: wstate_q <= CTD_W_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // narrow timer
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nen_dly_q    <= 1'b0;
            ncnt_q       <= `CTD_RST_BYTE;
            ncap_lo_q    <= `CTD_RST_BYTE;
            ncap_hi_q    <= `CTD_RST_BYTE;
            narrow_out_q <= 1'b1;
        end else if (ce) begin
            nen_dly_q <= nen;
            if (!nen) begin
                narrow_out_q <= ~common_q[`CTD_CC_STAT_RISE];
            end else if (!nen_dly_q || ntimeout) begin
                ncnt_q <= nreload_q;
                if (ntimeout && !demod) begin
                    narrow_out_q <= ~narrow_out_q;
                end
            end else begin
                ncnt_q <= ncnt_q - 8'h01;
            end
            if (ncap_ev && rise_p) begin
                ncap_hi_q <= ncnt_q;
            end
            if (ncap_ev && fall_p) begin
                ncap_lo_q <= ncnt_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // pins and interrupt pulses
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_out_pin_q       <= 1'b0;
            output_or_input_pin_q <= 1'b0;
            capture_irq_q         <= 1'b0;
            counter_irq_q         <= 1'b0;
        end else if (ce) begin
            timer_out_pin_q <= narrow_ctrl_q[`CTD_NC_ROUTE] ? narrow_out_q
                               : narrow_ctrl_q[`CTD_NC_PORT_A];
            output_or_input_pin_q <= (!demod && common_q[`CTD_CC_PINSEL]) ? wide_out_q
                                     : narrow_ctrl_q[`CTD_NC_PORT_B];
            capture_irq_q <= (wcap_ev & wide_ctrl_q[`CTD_WC_CAP_IE])
                           | (ncap_ev & narrow_ctrl_q[`CTD_NC_CAP_MASK]);
            counter_irq_q <= ntimeout & narrow_ctrl_q[`CTD_NC_CNT_MASK];
        end
    end

endmodule : ctd_top

//--- ctd_top_assertions.sv
// checker for the apb answer timing and interrupt pulses of the timer block
`timescale 1ns/1ps

module ctd_top_assertions (
    // clock, reset, enable
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [5:0]  paddr,
    input wire logic [31:0] prdata_q,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    // interrupts
    input wire logic        capture_irq_q,
    input wire logic        counter_irq_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------
    // bus phases
    // ------
    // setup seen by the slave while it is running
    sequence s_setup;
        ce && psel && !penable && !pready_q;
    endsequence
    // access phase completing
    sequence s_done;
        psel && penable && pready_q;
    endsequence

    a_ready_answers: assert property (s_setup |=> s_done)
        else $error("no zero-wait answer after setup");
    a_ready_single: assert property (pready_q && ce |=> !pready_q)
        else $error("ready held longer than one cycle");
    a_ready_cause: assert property ($rose(pready_q) |-> $past(psel && !penable))
        else $error("ready without a setup cycle");
    a_err_unmapped: assert property (s_setup ##0 (paddr[5:2] > 4'hA) |=> pslverr_q)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_setup ##0 (paddr[5:2] <= 4'hA) |=> !pslverr_q)
        else $error("mapped access refused");
    a_read_upper: assert property (pready_q |-> prdata_q[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    // ------
    // interrupt pulses
    // ------
    a_cap_pulse: assert property (capture_irq_q |=> !capture_irq_q)
        else $error("capture request longer than one cycle");
    a_cnt_pulse: assert property (counter_irq_q |=> !counter_irq_q)
        else $error("timeout request longer than one cycle");
endmodule : ctd_top_assertions

bind ctd_top ctd_top_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .capture_irq_q(capture_irq_q), .counter_irq_q(counter_irq_q)
);

//--- ctd_carrier_model.sv
// far-side carrier source driving the two demodulator input pins
`timescale 1ns/1ps

module ctd_carrier_model (
    // clock
    input wire logic pclk,
    // pins
    output logic     pin_a,
    output logic     pin_b
);
    // both pins rest high, like a pulled-up line
    initial begin
        pin_a = 1'b1;
        pin_b = 1'b1;
    end

    // one mark: chosen pin low for lo cycles, then high for hi cycles
    task automatic mark(input logic sel_b, input int lo, input int hi);
        @(posedge pclk);
        if (sel_b) begin
            pin_b <= 1'b0;
        end else begin
            pin_a <= 1'b0;
        end
        repeat (lo) @(posedge pclk);
        pin_a <= 1'b1;
        pin_b <= 1'b1;
        repeat (hi) @(posedge pclk);
    endtask : mark
endmodule : ctd_carrier_model

//--- carrier_timer_demodulator_tb.sv
// self-checking bench: apb register tasks and carrier-driven demodulation tests
`timescale 1ns/1ps
`include "ctd_params.svh"

module carrier_timer_demodulator_tb;
    // ------
    // signals
    // ------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata_q, rdata;
    logic        pready_q, pslverr_q, rerr, pin_a, pin_b, out_pin, out_b, cap_irq, cnt_irq;
    logic [15:0] wcap;
    logic [1:0]  st_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int          n_fail = 0;
    int          checks_done = 0;
    int          n_cap = 0;
    int          n_cnt = 0;

    always #12.5 pclk = ~pclk;

    ctd_top dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .demod_input_pin_a(pin_a),
        .demod_input_pin_b(pin_b), .timer_out_pin_q(out_pin), .output_or_input_pin_q(out_b),
        .capture_irq_q(cap_irq), .counter_irq_q(cnt_irq)
    );
    ctd_carrier_model carrier (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));

    // count interrupt pulses
    always @(posedge pclk) begin
        if (cap_irq === 1'b1) n_cap++;
        if (cnt_irq === 1'b1) n_cnt++;
    end

    // ------
    // tasks
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; holds the request until ready is sampled high
    task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_q !== 1'b1);
        rdata = prdata_q;
        rerr  = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rdata, exp);
    endtask : rd

    task automatic report_and_stop();
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // ------
    // tests
    // ------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, reserved bits, unmapped index
        rd(`CTD_IDX_COMMON, 32'h00000000);
        rd(`CTD_IDX_SHARED_THREE, 32'h0000001F);
        wr(`CTD_IDX_SHARED_THREE, 8'hE0);
        rd(`CTD_IDX_SHARED_THREE, 32'h000000FF);
        apb(1'b0, 4'hB, 8'h00);
        chk({rdata[30:0], rerr}, 32'h00000001);
        // idle narrow output and pin routing
        wr(`CTD_IDX_NARROW_CTRL, 8'h08);
        repeat (4) @(posedge pclk);
        chk({31'h0, out_pin}, 32'h1);
        wr(`CTD_IDX_COMMON, 8'h02);
        repeat (4) @(posedge pclk);
        chk({31'h0, out_pin}, 32'h0);
        wr(`CTD_IDX_NARROW_CTRL, 8'h30);
        repeat (4) @(posedge pclk);
        chk({31'h0, out_pin}, 32'h1);
        chk({31'h0, out_b}, 32'h1);
        // narrow timeout requests, masked and unmasked
        wr(`CTD_IDX_NRELOAD, 8'h04);
        wr(`CTD_IDX_NARROW_CTRL, 8'h05);
        n_cnt = 0;
        repeat (60) @(posedge pclk);
        chk({31'h0, n_cnt >= 10}, 32'h1);
        wr(`CTD_IDX_NARROW_CTRL, 8'h01);
        n_cnt = 0;
        repeat (40) @(posedge pclk);
        chk(n_cnt, 32'h0);
        wr(`CTD_IDX_NARROW_CTRL, 8'h00);
        // demodulation: gap of 51 cycles between falling edges
        wr(`CTD_IDX_WRELOAD_LOW, 8'hFF);
        wr(`CTD_IDX_WRELOAD_HIGH, 8'hFF);
        wr(`CTD_IDX_COMMON, 8'h80);
        wr(`CTD_IDX_WIDE_CTRL, 8'h84);
        wr(`CTD_IDX_COMMON, 8'h00);
        rd(`CTD_IDX_COMMON, 32'h00000080);
        n_cap = 0;
        carrier.mark(1'b0, 10, 40);
        carrier.mark(1'b0, 10, 40);
        apb(1'b0, `CTD_IDX_WCAP_HIGH, 8'h00);
        wcap[15:8] = rdata[7:0];
        apb(1'b0, `CTD_IDX_WCAP_LOW, 8'h00);
        wcap[7:0] = rdata[7:0];
        chk({31'h0, wcap >= 16'd48 && wcap <= 16'd52}, 32'h1);
        rd(`CTD_IDX_COMMON, 32'h00000081);
        rd(`CTD_IDX_COMMON, 32'h00000081);
        chk({31'h0, n_cap != 0}, 32'h1);
        // every edge code, capture interrupt off
        wr(`CTD_IDX_WIDE_CTRL, 8'h80);
        n_cap = 0;
        for (int code = 0; code < 4; code++) begin
            wr(`CTD_IDX_COMMON, 8'h83 | 8'(code << 4));
            carrier.mark(1'b0, 10, 30);
            rd(`CTD_IDX_COMMON, 32'h80 | 32'(code << 4) | 32'(st_tab[code]));
        end
        chk(n_cap, 32'h0);
        // glitch filter at its widest setting
        wr(`CTD_IDX_COMMON, 8'h8F);
        carrier.mark(1'b0, 3, 20);
        rd(`CTD_IDX_COMMON, 32'h0000008C);
        carrier.mark(1'b0, 12, 20);
        rd(`CTD_IDX_COMMON, 32'h0000008D);
        // input pin selection
        wr(`CTD_IDX_COMMON, 8'hC3);
        carrier.mark(1'b0, 10, 20);
        rd(`CTD_IDX_COMMON, 32'h000000C0);
        carrier.mark(1'b1, 10, 20);
        rd(`CTD_IDX_COMMON, 32'h000000C1);
        // narrow capture request on an edge of the selected pin
        wr(`CTD_IDX_NARROW_CTRL, 8'h03);
        n_cap = 0;
        carrier.mark(1'b1, 10, 20);
        chk({31'h0, n_cap != 0}, 32'h1);
        apb(1'b0, `CTD_IDX_NCAP_LOW, 8'h00);
        chk({31'h0, rdata[7:0] >= 8'h01 && rdata[7:0] <= 8'h04}, 32'h1);
        wr(`CTD_IDX_NARROW_CTRL, 8'h00);
        wr(`CTD_IDX_WIDE_CTRL, 8'h00);
        report_and_stop();
    end

    // watchdog well beyond the fewer than a thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end
endmodule : carrier_timer_demodulator_tb
